// [verilog/aid_regs.svh]
`ifndef AID_REGS_SVH
`define AID_REGS_SVH

// Register map of the analog input control block
`define AID_ANALOG_INPUT_CONTROL_ONE_ADDR 8'h02
`define AID_ANALOG_INPUT_CONTROL_ONE_RST 8'h00
`define AID_UNMAPPED_RDATA 8'h00

// Field positions inside analog_input_control_one
`define AID_FRONTEND_MSB 7
`define AID_FRONTEND_LSB 6
`define AID_MODE_MSB 5
`define AID_MODE_LSB 0

// Front-end function codes
`define AID_FRONTEND_AMP_ONLY 2'h2
`define AID_FRONTEND_AMP_AAF 2'h3

// Low-nibble codes that pick the x-1, x-2, x-3, x-4 input column
`define AID_LO_IN1 4'h0
`define AID_LO_IN2 4'h1
`define AID_LO_IN3 4'he
`define AID_LO_IN4 4'hf
// Second-group composite range and luma/chroma range
`define AID_LO_GRPB_FIRST 4'h2
`define AID_LO_GRPB_LAST 4'h5
`define AID_LO_YC_FIRST 4'h6
`define AID_LO_YC_LAST 4'hd
`define AID_LO_YC_UPPER 4'ha

`endif

// [verilog/aid_pkg.sv]
package aid_pkg;

  // Signal format driven onto the four channels, one-hot
  typedef enum logic [4:0] {
    AID_FMT_NONE = 5'h01,
    AID_FMT_CVBS = 5'h02,
    AID_FMT_YC = 5'h04,
    AID_FMT_YPBPR = 5'h08,
    AID_FMT_RGB = 5'h10
  } aid_format_t;

  // Per-channel routing word: enable, automatic gain, source pin
  typedef struct packed {
    logic en;
    logic agc;
    logic [3:0] src;
  } aid_route_t;

endpackage : aid_pkg

// [verilog/aid_ctrl_reg.sv]
`timescale 1ns/100ps
`include "aid_regs.svh"

module aid_ctrl_reg
  import aid_pkg::*;
(
  input wire logic core_clk, // System clock
  input wire logic sys_rst, // Synchronous reset, high
  input wire logic [7:0] reg_addr, // Subaddress of access
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe, one cycle
  input wire logic reg_rd, // Read strobe, one cycle
  output logic [7:0] reg_rdata, // Registered read data
  output logic [7:0] ctrl_value // Stored control byte
);

  logic [7:0] ctrl_r;
  logic [7:0] rdata_r;
  logic hit;

  // Address decode of the single control register
  assign hit = (reg_addr == `AID_ANALOG_INPUT_CONTROL_ONE_ADDR);
  assign ctrl_value = ctrl_r;
  assign reg_rdata = rdata_r;

  // Storage; reset gives mode 00 with front-end bypassed
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctrl_r <= `AID_ANALOG_INPUT_CONTROL_ONE_RST;
    end else if (reg_wr && hit) begin
      ctrl_r <= reg_wdata;
    end
  end

  // Read port; other subaddresses answer zero
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rdata_r <= `AID_UNMAPPED_RDATA;
    end else if (reg_rd) begin
      rdata_r <= hit ? ctrl_r : `AID_UNMAPPED_RDATA;
    end
  end

endmodule : aid_ctrl_reg

// [verilog/aid_mode_decoder.sv]
// Summary of operation
// R01: Codes 0E/0F: composite, auto gain, 1-3/1-4
// R02: Codes 10-15: composite from 3-1..4-4 order
// R03: 16/17: luma 3-x auto, chroma programmable gain
// R04: 18/19: luma 3-x, chroma gain tracks luma
// R05: 1A/1B: luma 3-3/3-4, programmable chroma gain
// R06: 1C/1D: luma 3-3/3-4, chroma follows luma
// R07: Codes 1E/1F: composite, auto gain, 3-3/3-4
// R08: Component: sync-channel gain; 20,21,2E,2F valid, rest reserved
// R09: Component 2E/2F use x-3/x-4 inputs
// R10: RGB: sync gain; 30,31,3E,3F; rest reserved
// R11: Host: group-1 capture codes and settings
// R12: Host: group-2 capture codes and settings
// R13: Host: group-3 capture codes and settings
// R14: Host: group-4 capture codes and settings
// R15: Host sets luma bandwidth bypass for Y/C
// R16: Bits 7:6 pick amplifier and filter
// R17: Host writes zero to unused bits
// R18: Outputs update next edge; reserved is inactive
// R19: Reset yields routing of code 00
`timescale 1ns/100ps
`include "aid_regs.svh"

module aid_mode_decoder
  import aid_pkg::*;
#(
  parameter int NUM_CHAN = 4
)(
  input wire logic core_clk, // System clock, 200 MHz
  input wire logic sys_rst, // Synchronous reset, high
  input wire logic [7:0] reg_addr, // Register subaddress
  input wire logic [7:0] reg_wdata, // Register write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [7:0] reg_rdata, // Read data, registered
  output logic [NUM_CHAN-1:0] chan_en, // Channel carries a signal
  output logic [NUM_CHAN-1:0] chan_agc, // Channel under automatic gain
  output logic [4*NUM_CHAN-1:0] chan_src, // Source pin per channel
  output logic chroma_gain_prog, // Chroma uses programmable gain
  output logic chroma_gain_track, // Chroma gain follows luma
  output logic [4:0] format, // One-hot signal format
  output logic mode_reserved, // Current code is reserved
  output logic amp_enable, // Front-end amplifier on
  output logic aaf_enable // Anti-alias filter on
);

  logic [7:0] ctrl_value;
  logic [5:0] mode;
  logic [1:0] frontend_function_select;
  logic [3:0] lo;
  logic is_col;
  logic is_grpb;
  logic is_yc;
  logic reserved_nxt;
  aid_format_t format_nxt;
  aid_format_t format_r;
  logic prog_nxt;
  logic track_nxt;
  logic prog_r;
  logic track_r;
  logic reserved_r;
  logic amp_r;
  logic aaf_r;
  aid_route_t route_nxt [NUM_CHAN];
  aid_route_t route_r [NUM_CHAN];

  // Register slot on the subaddress port
  aid_ctrl_reg u_ctrl (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .ctrl_value(ctrl_value)
  );

  // Field split
  assign mode = ctrl_value[`AID_MODE_MSB:`AID_MODE_LSB];
  assign frontend_function_select = ctrl_value[`AID_FRONTEND_MSB:`AID_FRONTEND_LSB];
  assign lo = mode[3:0];

  // Column codes shared by composite, component and RGB
  function automatic logic is_column(input logic [3:0] nib);
    is_column = (nib == `AID_LO_IN1) || (nib == `AID_LO_IN2) ||
                (nib == `AID_LO_IN3) || (nib == `AID_LO_IN4);
  endfunction : is_column

  // Column index: x-1, x-2, x-3, x-4
  function automatic logic [1:0] column_idx(input logic [3:0] nib);
    column_idx = {nib[3], nib[0]};
  endfunction : column_idx

  // Routing of one channel for a given mode code
  function automatic aid_route_t chan_route(input logic [5:0] m, input logic [1:0] ch);
    aid_route_t r;
    logic [3:0] n;
    logic [1:0] b;
    logic [1:0] idx;
    r = '0;
    n = m[3:0];
    // Pair base: groups 3/4 when code bit 4 is set, else groups 1/2
    b = m[4] ? 2'h2 : 2'h0;
    idx = 2'h0;
    if (m[5]) begin
      // Component or RGB on all groups, gain on sync channel only
      if (is_column(n)) begin // [R08] [R09] [R10]
        r.en = 1'b1;
        r.agc = (ch == 2'h0);
        idx = column_idx(n);
      end
    end else if (is_column(n)) begin
      // Composite from the first group of the pair
      if (ch == b) begin // [R01] [R07] [R02]
        r.en = 1'b1;
        r.agc = 1'b1;
        idx = column_idx(n);
      end
    end else if (n >= `AID_LO_GRPB_FIRST && n <= `AID_LO_GRPB_LAST) begin
      // Composite from the second group of the pair
      if (ch == b + 2'h1) begin // [R02]
        r.en = 1'b1;
        r.agc = 1'b1;
        idx = n[1:0] - 2'h2;
      end
    end else begin
      // Luma on first group with auto gain, chroma on second
      idx = {n >= `AID_LO_YC_UPPER, n[0]};
      if (ch == b) begin // [R03] [R04] [R05] [R06]
        r.en = 1'b1;
        r.agc = 1'b1;
      end else if (ch == b + 2'h1) begin
        r.en = 1'b1;
      end
    end
    r.src = {ch, idx};
    chan_route = r;
  endfunction : chan_route

  // Mode classification
  assign is_col = is_column(lo);
  assign is_grpb = (lo >= `AID_LO_GRPB_FIRST) && (lo <= `AID_LO_GRPB_LAST);
  assign is_yc = !mode[5] && (lo >= `AID_LO_YC_FIRST) && (lo <= `AID_LO_YC_LAST);
  assign reserved_nxt = mode[5] && !is_col; // [R08] [R10]

  // Chroma gain policy: programmable on 6,7,A,B; tracking on 8,9,C,D
  assign prog_nxt = is_yc && lo[1]; // [R03] [R05]
  assign track_nxt = is_yc && !lo[1]; // [R04] [R06]

  // Format selection; reserved codes leave every channel idle
  always_comb begin
    if (reserved_nxt) begin
      format_nxt = AID_FMT_NONE; // [R18]
    end else if (mode[5] && mode[4]) begin
      format_nxt = AID_FMT_RGB; // [R10]
    end else if (mode[5]) begin
      format_nxt = AID_FMT_YPBPR; // [R08] [R09]
    end else if (is_yc) begin
      format_nxt = AID_FMT_YC;
    end else if (is_col || is_grpb) begin
      format_nxt = AID_FMT_CVBS;
    end else begin
      format_nxt = AID_FMT_NONE;
    end
  end

  // Per-channel routing, registered one edge after the write
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CHAN; gi++) begin : g_chan
      assign route_nxt[gi] = chan_route(mode, 2'(gi));

      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          route_r[gi] <= chan_route(6'h00, 2'(gi)); // [R19]
        end else begin
          route_r[gi] <= route_nxt[gi]; // [R18]
        end
      end

      assign chan_en[gi] = route_r[gi].en;
      assign chan_agc[gi] = route_r[gi].agc;
      assign chan_src[4*gi +: 4] = route_r[gi].src;
    end
  endgenerate

  // Format and gain policy registers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      format_r <= AID_FMT_CVBS; // [R19]
      prog_r <= 1'b0;
      track_r <= 1'b0;
      reserved_r <= 1'b0;
    end else begin
      format_r <= format_nxt; // [R18]
      prog_r <= prog_nxt;
      track_r <= track_nxt;
      reserved_r <= reserved_nxt;
    end
  end

  // Front-end control; 00 and 01 bypass both stages
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      amp_r <= 1'b0;
      aaf_r <= 1'b0;
    end else begin
      amp_r <= (frontend_function_select == `AID_FRONTEND_AMP_ONLY) ||
               (frontend_function_select == `AID_FRONTEND_AMP_AAF); // [R16]
      aaf_r <= (frontend_function_select == `AID_FRONTEND_AMP_AAF); // [R16]
    end
  end

  // Output drive
  assign format = format_r;
  assign chroma_gain_prog = prog_r;
  assign chroma_gain_track = track_r;
  assign mode_reserved = reserved_r;
  assign amp_enable = amp_r;
  assign aaf_enable = aaf_r;

endmodule : aid_mode_decoder

// [verification/aid_mode_decoder_props.sv]
`timescale 1ns/100ps
module aid_mode_decoder_props #(
  parameter int NUM_CHAN = 4
)(
  input wire logic core_clk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic [7:0] reg_addr, // Address
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [7:0] reg_rdata, // Read data
  input wire logic [NUM_CHAN-1:0] chan_en, // Enables
  input wire logic [NUM_CHAN-1:0] chan_agc, // Gain flags
  input wire logic [4*NUM_CHAN-1:0] chan_src, // Sources
  input wire logic chroma_gain_prog, // Programmable chroma gain
  input wire logic chroma_gain_track, // Chroma gain follows luma
  input wire logic [4:0] format, // Format
  input wire logic mode_reserved, // Reserved code
  input wire logic amp_enable, // Amplifier
  input wire logic aaf_enable // Filter
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Write to the control byte and its input column
  wire wr = reg_wr && reg_addr == 8'h02;
  wire [3:0] lo = reg_wdata[3:0];
  wire ok = lo == 4'h0 || lo == 4'h1 || lo == 4'he || lo == 4'hf;
  // Output relations, two edges after the write
  property p_fe;
    wr |-> ##2 {amp_enable, aaf_enable} == {$past(reg_wdata[7], 2), &$past(reg_wdata[7:6], 2)};
  endproperty
  a_fe: assert property (p_fe) else $error("front-end bits wrong");
  property p_res; wr && reg_wdata[5] && !ok |-> ##2 mode_reserved && chan_en == '0; endproperty
  a_res: assert property (p_res) else $error("reserved code routed");
  property p_cmp;
    wr && reg_wdata[5:4] == 2'h2 && ok |->
      ##2 format == 5'h08 && chan_en == 4'hf && chan_agc == 4'h1;
  endproperty
  a_cmp: assert property (p_cmp) else $error("component mode wrong");
  property p_rgb;
    wr && reg_wdata[5:4] == 2'h3 && ok |-> ##2 format == 5'h10 && chan_agc == 4'h1;
  endproperty
  a_rgb: assert property (p_rgb) else $error("rgb mode wrong");
  property p_cv3;
    wr && reg_wdata[5:1] == 5'h0f |-> ##2 chan_src[11:8] == {3'h5, $past(reg_wdata[0], 2)};
  endproperty
  a_cv3: assert property (p_cv3) else $error("composite group three wrong");
  property p_yc;
    wr && reg_wdata[5:4] == 2'h1 && lo > 4'h5 && lo < 4'he |-> ##2 chan_en == 4'hc;
  endproperty
  a_yc: assert property (p_yc) else $error("luma chroma pair wrong");
  // Chroma gain policy: bit 1 of the code picks programmable over tracking
  property p_gain;
    wr && !reg_wdata[5] && lo > 4'h5 && lo < 4'he |->
      ##2 chroma_gain_prog == $past(reg_wdata[1], 2) &&
      chroma_gain_track == !$past(reg_wdata[1], 2);
  endproperty
  a_gain: assert property (p_gain) else $error("chroma gain policy wrong");
  property p_rd; reg_rd && reg_addr != 8'h02 |=> reg_rdata == 8'h00; endproperty
  a_rd: assert property (p_rd) else $error("unmapped read not zero");
  property p_hold; !wr [*2] |=> $stable(format) && $stable(chan_en); endproperty
  a_hold: assert property (p_hold) else $error("outputs moved without write");
  c_res: cover property (wr && reg_wdata[5] && !ok);
  c_rgb: cover property (wr && reg_wdata[5:4] == 2'h3 && ok);
  c_unm: cover property (reg_rd && reg_addr != 8'h02);
endmodule : aid_mode_decoder_props
bind aid_mode_decoder aid_mode_decoder_props #(.NUM_CHAN(NUM_CHAN)) u_props (.core_clk, .sys_rst,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .chan_en, .chan_agc, .chan_src, .format,
  .chroma_gain_prog, .chroma_gain_track, .mode_reserved, .amp_enable, .aaf_enable);

// [verification/aid_host_model.sv]
`timescale 1ns/100ps
module aid_host_model (
  input wire logic core_clk, // Clock
  output logic [7:0] reg_addr, // Address
  output logic [7:0] reg_wdata, // Write data
  output logic reg_wr, // Write strobe
  output logic reg_rd, // Read strobe
  input wire logic [7:0] reg_rdata // Read data
);
  // Idle bus at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // One-cycle write, every bit of the byte set on purpose
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d; // No stale data left on the bus
  endtask : wr
  // One-cycle read, data taken after the sampling edge
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    q = reg_rdata;
  endtask : rd
endmodule : aid_host_model

// [verification/tb_analog_input_mode_decoder.sv]
`timescale 1ns/100ps
module tb_analog_input_mode_decoder;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  wire [7:0] reg_addr, reg_wdata, reg_rdata;
  wire reg_wr, reg_rd, chroma_gain_prog, chroma_gain_track, mode_reserved, amp_enable, aaf_enable;
  wire [3:0] chan_en, chan_agc;
  wire [15:0] chan_src;
  wire [4:0] format;
  wire [31:0] seen = {chan_en, chan_agc, chan_src, format, chroma_gain_prog, chroma_gain_track,
    mode_reserved};
  int failures = 0;
  int checks_done = 0;
  // Capture codes of groups 1 to 4, four per group, lowest first
  localparam logic [95:0] cap_codes = {6'h15, 6'h14, 6'h13, 6'h12, 6'h1f, 6'h1e, 6'h11, 6'h10,
    6'h05, 6'h04, 6'h03, 6'h02, 6'h0f, 6'h0e, 6'h01, 6'h00};
  // Clock and hang guard
  always #2.5 core_clk = ~core_clk;
  initial begin
    repeat (100000) @(posedge core_clk);
    failures++;
    report_and_stop();
  end
  aid_host_model u_host (.core_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  aid_mode_decoder #(.NUM_CHAN(4)) u_dut (.core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .chan_en, .chan_agc, .chan_src, .chroma_gain_prog, .chroma_gain_track,
    .format, .mode_reserved, .amp_enable, .aaf_enable);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic report_and_stop();
    if (failures == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop
  // Expected routing word of a mode code
  function automatic logic [31:0] expv(input logic [5:0] c);
    logic [3:0] lo, en, agc;
    logic [1:0] b, i;
    logic [15:0] s;
    logic [4:0] f;
    logic p, t, r;
    lo = c[3:0];
    b = {c[4], 1'b0};
    i = lo[1:0];
    {en, agc, s, f, p, t, r} = {8'h00, 16'h0000, 5'h01, 3'h0};
    if (c[5]) begin
      if (lo inside {0, 1, 14, 15}) begin
        {en, agc, f} = {8'hf1, c[4] ? 5'h10 : 5'h08};
        s = {2'd3, i, 2'd2, i, 2'd1, i, 2'd0, i};
      end else r = 1'b1;
    end else if (lo inside {0, 1, 14, 15}) begin
      {en[b], agc[b], f} = {2'b11, 5'h02};
      s[4*b+:4] = {b, i};
    end else if (lo <= 4'h5) begin
      {en[b+1], agc[b+1], f} = {2'b11, 5'h02};
      s[4*(b+1)+:4] = {b + 2'd1, lo[1:0] - 2'd2};
    end else begin
      i = {lo >= 4'ha, lo[0]};
      {en[b], en[b+1], agc[b], f, p, t} = {3'b111, 5'h04, lo[1], ~lo[1]};
      s[4*b+:4] = {b, i};
      s[4*(b+1)+:4] = {b + 2'd1, i};
    end
    return {en, agc, s, f, p, t, r};
  endfunction : expv
  // Compare every decoded output, sources only where enabled
  task automatic look(input logic [7:0] d);
    logic [31:0] e;
    logic [15:0] m;
    e = expv(d[5:0]);
    for (int k = 0; k < 4; k++) m[4*k+:4] = {4{e[28+k]}};
    chk(seen & {8'hff, m, 8'hff}, e);
    chk({amp_enable, aaf_enable}, {d[7], &d[7:6]});
  endtask : look
  // Reset, full code sweep, then an unmapped place
  initial begin
    logic [7:0] d;
    logic [7:0] q;
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    #1;
    look(8'h00);
    u_host.rd(8'h02, q);
    chk(q, 8'h00);
    for (int n = 0; n < 64; n++) begin
      d = {n[1:0], n[5:0]};
      u_host.wr(8'h02, d);
      repeat (2) @(posedge core_clk);
      #1;
      look(d);
      u_host.rd(8'h02, q);
      chk(q, d);
    end
    u_host.wr(8'h03, 8'h5a);
    repeat (2) @(posedge core_clk);
    #1;
    look(d);
    u_host.rd(8'h03, q);
    chk(q, 8'h00);
    u_host.rd(8'h02, q);
    chk(q, d);
    // Capture codes; the live channel equals the host's output select
    for (int j = 0; j < 16; j++) begin
      d = {2'b00, cap_codes[6*j+:6]};
      u_host.wr(8'h02, d);
      repeat (2) @(posedge core_clk);
      #1;
      chk(chan_en, 32'h0000_0001 << (j / 4));
      look(d);
    end
    // Bypass bit lives in another register; a Y/C mode must not see it
    u_host.wr(8'h02, 8'h16);
    u_host.wr(8'h09, 8'h80);
    repeat (2) @(posedge core_clk);
    #1;
    look(8'h16);
    u_host.rd(8'h09, q);
    chk(q, 8'h00);
    report_and_stop();
  end
endmodule : tb_analog_input_mode_decoder
